/* File: i2c_host.sv */
// I2C master model that runs transfers on the sensor's serial pins
`timescale 1ns/1ns
module i2c_host (
  input wire logic clock,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0
);
  int ph = 6; // Cycles per quarter bit, larger for a slow host
  // Quarter bit wait, resuming just after an edge
  task automatic hold();
    repeat (ph) @(posedge clock);
    #1;
  endtask
  // One bit: data set while SCL low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    hold();
    scl = 1'b0;
    hold();
  endtask
  // Byte MSB first, then acknowledge bit
  task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
    output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(last, ack);
  endtask
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
endmodule // i2c_host

/* File: light_sensor_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sensor register slice
// Overview of operation
// - Repeat shorter than conversion runs at conversion rate
// - Resolution bits 6:4 pick 20..13 bits
// - Resolution resets to code 010, 100 ms
// - Repeat bits 2:0 pick 25..2000 ms
// - Timing register resets 0x22, bits 7,3 zero
// - Gain bits 2:0 pick 1,3,6,9,18
// - Gain register resets 0x01, bits 7:3 reserved
// - Identification register read-only, part and revision
// - Interrupt flag bit 4 on persistent out-of-range
// - Reading status clears interrupt flag
// - Power-on flag bit 5 set, read clears
// - New-data flag bit 3, read clears
// - Status register resets to 0x20
// - Mode control write restarts the measurement
// - Result bytes frozen during reads of 0x07..0x12
// - Persist setting plus one gives needed out-of-range count
`ifndef LIGHT_SENSOR_CFG_SVH
`define LIGHT_SENSOR_CFG_SVH
`define SLAVE_ADDR 7'h53
`define OFS_MODE_CTRL 8'h00
`define OFS_TIMING 8'h04
`define OFS_GAIN 8'h05
`define OFS_IDENT 8'h06
`define OFS_STATUS 8'h07
`define OFS_AMB_0 8'h0D
`define OFS_AMB_1 8'h0E
`define OFS_AMB_2 8'h0F
`define OFS_UV_0 8'h10
`define OFS_UV_1 8'h11
`define OFS_UV_2 8'h12
`define TIMING_RESET 8'h22
`define TIMING_MASK 8'h77
`define GAIN_RESET 8'h01
`define GAIN_MASK 8'h07
`define STATUS_RESET 8'h20
`define RES_LSB 4
`define RATE_LSB 0
`define ST_PWR_BIT 5
`define ST_INT_BIT 4
`define ST_NEW_BIT 3
`define CLK_PERIOD_NS 10
`define HALF_MS_NS 500000
// Conversion times in half milliseconds
`define CONV_400 13'd800
`define CONV_200 13'd400
`define CONV_100 13'd200
`define CONV_50 13'd100
`define CONV_25 13'd50
`define CONV_12P5 13'd25
// Repeat intervals in half milliseconds
`define REP_25 13'd50
`define REP_50 13'd100
`define REP_100 13'd200
`define REP_200 13'd400
`define REP_500 13'd1000
`define REP_1000 13'd2000
`define REP_2000 13'd4000
`endif

/* File: light_sensor_meas_config_status_bench.sv */
// Self-checking bench for the sensor register slice
`timescale 1ns/1ns
module light_sensor_meas_config_status_bench;
  localparam int H = 2;
  logic clock = 0, rst_n = 0, meas_enable = 0, result_is_uv = 0, result_valid = 0;
  logic int_enable = 1, int_sel_uv = 0, scl_i, sda_low, sda_o, sda_oe, conv_start, mode_wr, ak;
  logic [19:0] result_data = 0, upper_limit = 20'h3E8, lower_limit = 20'hA, d, pend;
  logic [19:0] res[2] = '{20'h0, 20'h0};
  logic [3:0] out_of_range_count_setting = 4'h2;
  logic [2:0] resolution_code, gain_code;
  logic [7:0] mode_wdata, rb, st = 8'h20;
  logic [7:0] q[$];
  wire sda_i = !((sda_oe && !sda_o) || sda_low); // Pull-up unless pulled low
  int num_errors = 0, check_count = 0, cnt = 0, n;
  int pace[4][3] = '{'{2, 2, 200}, '{0, 0, 800}, '{5, 0, 50}, '{5, 7, 4000}};
  // Identity values are arbitrary
  light_sensor_regs #(.HALF_MS_CYCLES(H), .PART_NUMBER(4'hC), .REVISION(4'h7))
    light_sensor_regs_i (.clock, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .meas_enable,
    .result_is_uv, .result_valid, .result_data, .int_enable, .int_sel_uv, .upper_limit,
    .lower_limit, .out_of_range_count_setting, .conv_start, .resolution_code, .gain_code,
    .mode_wr, .mode_wdata);
  i2c_host i2c_host_i (.clock, .sda(sda_i), .scl(scl_i), .sda_low);
  initial forever #5 clock = !clock;
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One result pulse, updating reference flags and persist count
  task automatic pulse(input logic uv, input logic [19:0] v);
    result_is_uv = uv;
    result_data = v;
    result_valid = 1'b1;
    @(posedge clock);
    #1 result_valid = 1'b0;
    res[uv] = v;
    if (uv == int_sel_uv && (v > upper_limit || v < lower_limit)) begin
      if (cnt >= out_of_range_count_setting) st = st | 8'h10;
      cnt++;
    end else if (uv == int_sel_uv) begin
      cnt = 0;
    end
    st = st | 8'h08;
  endtask
  task automatic point(input logic [7:0] p);
    i2c_host_i.start();
    i2c_host_i.xfer(8'hA6, 1'b1, rb, ak);
    i2c_host_i.xfer(p, 1'b1, rb, ak);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    point(p);
    i2c_host_i.xfer(v, 1'b1, rb, ak);
    i2c_host_i.stop();
  endtask
  // Burst read into q, optional result arriving after the first byte
  task automatic rd(input logic [7:0] p, input int len, input logic mid);
    q = {};
    point(p);
    i2c_host_i.start();
    i2c_host_i.xfer(8'hA7, 1'b1, rb, ak);
    for (int i = 0; i < len; i++) begin
      i2c_host_i.xfer(8'hFF, i == len - 1, rb, ak);
      q.push_back(rb);
      if (mid && i == 0) pulse(1'b0, pend);
    end
    i2c_host_i.stop();
  endtask
  // Cycles until the next conversion start, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clock);
      #1 c++;
      if (c > 10000) begin
        num_errors++;
        wrap_up();
      end
    end while (!conv_start);
  endtask
  initial begin
    void'($urandom(32'h58e733d5));
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    rd(8'h04, 4, 1'b0);
    check(q[0], 8'h22);
    check(q[1], 8'h01);
    check(q[2], 8'hC7);
    check(q[3], st);
    st = 8'h00;
    if (q[3][5]) wr(8'h05, 8'h01);
    // Gain codes with random reserved bits
    for (int g = 0; g < 5; g++) begin
      n = $urandom;
      wr(8'h05, {n[7:3], g[2:0]});
      rd(8'h05, 1, 1'b0);
      check(q[0], 20'(g));
      check(gain_code, 20'(g));
    end
    // Resolution codes, reserved ones included
    for (int r = 0; r < 8; r++) begin
      n = $urandom;
      wr(8'h04, {n[7], r[2:0], n[3:0]});
      rd(8'h04, 1, 1'b0);
      check(q[0], {1'b0, r[2:0], 1'b0, n[2:0]});
      check(resolution_code, 20'(r));
    end
    wr(8'h06, 8'h00);
    rd(8'h06, 1, 1'b0);
    check(q[0], 8'hC7);
    // Pacing after a restart for several timing pairs
    meas_enable = 1'b1;
    foreach (pace[i]) begin
      wr(8'h04, {1'b0, pace[i][0][2:0], 1'b0, pace[i][1][2:0]});
      n = $urandom;
      wr(8'h00, n[7:0]);
      check(mode_wdata, n[7:0]);
      gap(n);
      gap(n);
      check(20'(n), 20'(pace[i][2] * H));
    end
    // Persistent out-of-range results with a slow host
    i2c_host_i.ph = 12;
    pulse(1'b0, 20'd2000);
    n = $urandom;
    pulse(1'b1, n[19:0]);
    pulse(1'b0, 20'd2000);
    rd(8'h07, 1, 1'b0);
    check(q[0], st);
    st = 8'h00;
    n = $urandom;
    pulse(1'b0, n[19:0] | 20'h80000);
    rd(8'h07, 1, 1'b0);
    check(q[0], st);
    st = 8'h00;
    rd(8'h07, 1, 1'b0);
    check(q[0], st);
    // Interrupt source moved to the ultraviolet channel
    int_sel_uv = 1'b1;
    pulse(1'b1, {17'h0, n[2:0]});
    rd(8'h07, 1, 1'b0);
    check(q[0], st);
    st = 8'h00;
    // Result bytes stay from one measurement during a burst
    d = res[0];
    n = $urandom;
    pend = {~d[19:16], n[15:0]};
    rd(8'h0D, 6, 1'b1);
    check({q[2][3:0], q[1], q[0]}, d);
    check({q[5][3:0], q[4], q[3]}, res[1]);
    rd(8'h0D, 3, 1'b0);
    check({q[2][3:0], q[1], q[0]}, res[0]);
    // Mid-run reset brings the defaults back
    meas_enable = 1'b0;
    rst_n = 1'b0;
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(resolution_code, 20'h2);
    check(gain_code, 20'h1);
    rd(8'h04, 4, 1'b0);
    check(q[0], 8'h22);
    check(q[1], 8'h01);
    check(q[3], 8'h20);
    wrap_up();
  end
endmodule // light_sensor_meas_config_status_bench

/* File: light_sensor_pkg.sv */
// Types shared by the sensor register slice
package light_sensor_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RX = 3'b010,
    ST_RACK = 3'b110,
    ST_TX = 3'b111,
    ST_TACK = 3'b101
  } i2c_state_e;
endpackage

/* File: light_sensor_regs.sv */
// I2C register slice: timing, gain, identification, status and result lock
`timescale 1ns/1ns
`include "light_sensor_cfg.svh"
module light_sensor_regs #(
  parameter int HALF_MS_CYCLES = `HALF_MS_NS / `CLK_PERIOD_NS,
  parameter logic [3:0] PART_NUMBER = 4'h5, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic meas_enable,
  input wire logic result_is_uv,
  input wire logic result_valid,
  input wire logic [19:0] result_data,
  input wire logic int_enable,
  input wire logic int_sel_uv,
  input wire logic [19:0] upper_limit,
  input wire logic [19:0] lower_limit,
  input wire logic [3:0] out_of_range_count_setting,
  output logic conv_start,
  output logic [2:0] resolution_code,
  output logic [2:0] gain_code,
  output logic mode_wr,
  output logic [7:0] mode_wdata
);
  logic [1:0] rst_sync_ff;
  logic rst_sync_n;
  logic [2:0] scl_ff, sda_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  light_sensor_pkg::i2c_state_e state_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff, ptr_ff, tx_ff;
  logic rw_ff, first_ff, acked_ff, oe_ff, mode_wr_ff;
  logic [7:0] timing_ff, gain_ff, mode_wdata_ff;
  logic pwr_ff, int_ff, new_ff;
  logic [19:0] amb_ff, uv_ff, amb_tmp_ff, uv_tmp_ff;
  logic amb_pend_ff, uv_pend_ff;
  logic [4:0] persist_ff;
  logic [16:0] pre_ff;
  logic [12:0] ivl_ff;
  logic en_d_ff, start_ff;
  logic rx_done, wr_strobe, load_tx, status_clr, locked, out_range, restart, tick;
  logic [12:0] period;

  // Conversion time per resolution code
  function automatic logic [12:0] conv_len(input logic [2:0] c);
    unique case (c)
      3'd0: conv_len = `CONV_400;
      3'd1: conv_len = `CONV_200;
      3'd2: conv_len = `CONV_100;
      3'd3: conv_len = `CONV_50;
      3'd4: conv_len = `CONV_25;
      default: conv_len = `CONV_12P5;
    endcase
  endfunction

  // Repeat interval per rate code
  function automatic logic [12:0] rep_len(input logic [2:0] c);
    unique case (c)
      3'd0: rep_len = `REP_25;
      3'd1: rep_len = `REP_50;
      3'd2: rep_len = `REP_100;
      3'd3: rep_len = `REP_200;
      3'd4: rep_len = `REP_500;
      3'd5: rep_len = `REP_1000;
      default: rep_len = `REP_2000;
    endcase
  endfunction

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // Pin synchronisers plus one history stage
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_ff <= 3'b111;
      sda_ff <= 3'b111;
    end else begin
      scl_ff <= {scl_ff[1:0], scl_i};
      sda_ff <= {sda_ff[1:0], sda_i};
    end
  end
  assign scl_rise = scl_ff[1] & ~scl_ff[2];
  assign scl_fall = ~scl_ff[1] & scl_ff[2];
  assign bus_start = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
  assign bus_stop = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];

  // Byte events of the slave
  assign rx_done = scl_fall && bitcnt_ff == 4'd8;
  assign wr_strobe = state_ff == light_sensor_pkg::ST_RX && rx_done && !first_ff;
  assign load_tx = scl_fall && ((state_ff == light_sensor_pkg::ST_AACK && rw_ff) ||
                   (state_ff == light_sensor_pkg::ST_TACK && acked_ff));
  assign status_clr = load_tx && ptr_ff == `OFS_STATUS;
  assign locked = rw_ff && state_ff != light_sensor_pkg::ST_IDLE &&
                  ptr_ff >= `OFS_STATUS && ptr_ff <= `OFS_UV_2;

  // Read multiplexer, unmapped and reserved bits read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    unique case (a)
      `OFS_TIMING: rd_byte = timing_ff & `TIMING_MASK;
      `OFS_GAIN: rd_byte = gain_ff & `GAIN_MASK;
      `OFS_IDENT: rd_byte = {PART_NUMBER, REVISION};
      `OFS_STATUS: rd_byte = {2'b00, pwr_ff, int_ff, new_ff, 3'b000};
      `OFS_AMB_0: rd_byte = amb_ff[7:0];
      `OFS_AMB_1: rd_byte = amb_ff[15:8];
      `OFS_AMB_2: rd_byte = {4'h0, amb_ff[19:16]};
      `OFS_UV_0: rd_byte = uv_ff[7:0];
      `OFS_UV_1: rd_byte = uv_ff[15:8];
      `OFS_UV_2: rd_byte = {4'h0, uv_ff[19:16]};
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // I2C slave sequencer
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= light_sensor_pkg::ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      acked_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff <= light_sensor_pkg::ST_ADDR;
      bitcnt_ff <= 4'h0;
      rw_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff <= light_sensor_pkg::ST_IDLE;
      rw_ff <= 1'b0;
    end else begin
      if (scl_rise && bitcnt_ff != 4'd8 &&
          (state_ff == light_sensor_pkg::ST_ADDR || state_ff == light_sensor_pkg::ST_RX)) begin
        shift_ff <= {shift_ff[6:0], sda_ff[1]};
        bitcnt_ff <= bitcnt_ff + 4'd1;
      end
      if (load_tx) begin
        tx_ff <= rd_byte(ptr_ff);
        ptr_ff <= ptr_ff + 8'h01;
        bitcnt_ff <= 4'h0;
        acked_ff <= 1'b0;
        state_ff <= light_sensor_pkg::ST_TX;
      end else begin
        unique case (state_ff)
          light_sensor_pkg::ST_IDLE: begin
          end
          light_sensor_pkg::ST_ADDR: begin
            if (rx_done) begin
              if (shift_ff[7:1] == `SLAVE_ADDR) begin
                state_ff <= light_sensor_pkg::ST_AACK;
                rw_ff <= shift_ff[0];
              end else begin
                state_ff <= light_sensor_pkg::ST_IDLE;
              end
            end
          end
          light_sensor_pkg::ST_AACK: begin
            if (scl_fall) begin
              state_ff <= light_sensor_pkg::ST_RX;
              bitcnt_ff <= 4'h0;
              first_ff <= 1'b1;
            end
          end
          light_sensor_pkg::ST_RX: begin
            if (rx_done) begin
              state_ff <= light_sensor_pkg::ST_RACK;
              first_ff <= 1'b0;
              ptr_ff <= first_ff ? shift_ff : ptr_ff + 8'h01;
            end
          end
          light_sensor_pkg::ST_RACK: begin
            if (scl_fall) begin
              state_ff <= light_sensor_pkg::ST_RX;
              bitcnt_ff <= 4'h0;
            end
          end
          light_sensor_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_ff == 4'd7) begin
                state_ff <= light_sensor_pkg::ST_TACK;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                bitcnt_ff <= bitcnt_ff + 4'd1;
              end
            end
          end
          light_sensor_pkg::ST_TACK: begin
            if (scl_rise) begin
              if (sda_ff[1]) begin
                state_ff <= light_sensor_pkg::ST_IDLE;
              end else begin
                acked_ff <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Data line drive: acknowledge or transmit a zero
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= state_ff == light_sensor_pkg::ST_AACK || state_ff == light_sensor_pkg::ST_RACK ||
               (state_ff == light_sensor_pkg::ST_TX && !tx_ff[7]);
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;

  // Writable configuration registers
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timing_ff <= `TIMING_RESET;
      gain_ff <= `GAIN_RESET;
      mode_wr_ff <= 1'b0;
      mode_wdata_ff <= 8'h00;
    end else begin
      mode_wr_ff <= wr_strobe && ptr_ff == `OFS_MODE_CTRL;
      if (wr_strobe && ptr_ff == `OFS_MODE_CTRL) begin
        mode_wdata_ff <= shift_ff;
      end
      if (wr_strobe && ptr_ff == `OFS_TIMING) begin
        timing_ff <= shift_ff & `TIMING_MASK;
      end
      if (wr_strobe && ptr_ff == `OFS_GAIN) begin
        gain_ff <= shift_ff & `GAIN_MASK;
      end
    end
  end
  assign mode_wr = mode_wr_ff;
  assign mode_wdata = mode_wdata_ff;
  assign resolution_code = timing_ff[`RES_LSB +: 3];
  assign gain_code = gain_ff[2:0];

  // Measurement pacing in half-millisecond ticks
  assign period = rep_len(timing_ff[`RATE_LSB +: 3]) > conv_len(resolution_code) ?
                  rep_len(timing_ff[`RATE_LSB +: 3]) : conv_len(resolution_code);
  assign restart = mode_wr_ff || (meas_enable && !en_d_ff);
  assign tick = pre_ff == 17'(HALF_MS_CYCLES - 1);
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_ff <= 17'h0;
      ivl_ff <= 13'h0;
      en_d_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      en_d_ff <= meas_enable;
      start_ff <= 1'b0;
      if (restart || !meas_enable) begin
        pre_ff <= 17'h0;
        ivl_ff <= 13'h0;
        start_ff <= meas_enable;
      end else begin
        pre_ff <= tick ? 17'h0 : pre_ff + 17'h1;
        if (tick) begin
          if (ivl_ff >= period - 13'h1) begin
            ivl_ff <= 13'h0;
            start_ff <= 1'b1;
          end else begin
            ivl_ff <= ivl_ff + 13'h1;
          end
        end
      end
    end
  end
  assign conv_start = start_ff;

  // Result capture with freeze while a read covers the result range
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      amb_ff <= 20'h0;
      uv_ff <= 20'h0;
      amb_tmp_ff <= 20'h0;
      uv_tmp_ff <= 20'h0;
      amb_pend_ff <= 1'b0;
      uv_pend_ff <= 1'b0;
    end else begin
      if (result_valid && !result_is_uv) begin
        amb_tmp_ff <= result_data;
        amb_pend_ff <= 1'b1;
      end else if (!locked && amb_pend_ff) begin
        amb_ff <= amb_tmp_ff;
        amb_pend_ff <= 1'b0;
      end
      if (result_valid && result_is_uv) begin
        uv_tmp_ff <= result_data;
        uv_pend_ff <= 1'b1;
      end else if (!locked && uv_pend_ff) begin
        uv_ff <= uv_tmp_ff;
        uv_pend_ff <= 1'b0;
      end
    end
  end

  // Consecutive out-of-range counter on the selected channel
  assign out_range = result_data > upper_limit || result_data < lower_limit;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      persist_ff <= 5'h0;
    end else if (result_valid && result_is_uv == int_sel_uv) begin
      if (!out_range) begin
        persist_ff <= 5'h0;
      end else if (persist_ff != 5'h1F) begin
        persist_ff <= persist_ff + 5'h1;
      end
    end
  end

  // Status flags: hardware set wins over read clear
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pwr_ff <= 1'b1;
      int_ff <= 1'b0;
      new_ff <= 1'b0;
    end else begin
      if (status_clr) begin
        pwr_ff <= 1'b0;
      end
      if (int_enable && result_valid && result_is_uv == int_sel_uv && out_range &&
          persist_ff >= {1'b0, out_of_range_count_setting}) begin
        int_ff <= 1'b1;
      end else if (status_clr) begin
        int_ff <= 1'b0;
      end
      if (result_valid) begin
        new_ff <= 1'b1;
      end else if (status_clr) begin
        new_ff <= 1'b0;
      end
    end
  end
endmodule // light_sensor_regs

/* File: light_sensor_regs_sva.sv */
// Port checker for the sensor register slice
`timescale 1ns/1ns
module light_sensor_regs_sva #(
  parameter int HALF_MS_CYCLES = 50000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic meas_enable,
  input wire logic mode_wr,
  input wire logic conv_start,
  input wire logic [2:0] resolution_code,
  input wire logic [2:0] gain_code
);
  int gap_ff;
  // Cycles since the last start, restart or idle cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 0;
    end else if (conv_start || mode_wr || !meas_enable) begin
      gap_ff <= 0;
    end else begin
      gap_ff <= gap_ff + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  restart_pulse_a: assert property (mode_wr && meas_enable |=> conv_start)
    else $error("no start after mode write");
  start_single_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  idle_quiet_a: assert property (!meas_enable && !$past(meas_enable) |-> !conv_start)
    else $error("start while disabled");
  res_reset_a: assert property ($rose(rst_n) |-> resolution_code == 3'h2)
    else $error("bad resolution reset");
  gain_reset_a: assert property ($rose(rst_n) |-> gain_code == 3'h1)
    else $error("bad gain reset");
  mode_single_a: assert property (mode_wr |=> !mode_wr)
    else $error("mode write pulse too long");
  gap_min_a: assert property (conv_start && gap_ff > 1 |-> gap_ff >= 25 * HALF_MS_CYCLES - 1)
    else $error("starts closer than fastest conversion");
  gap_max_a: assert property (gap_ff < 4000 * HALF_MS_CYCLES)
    else $error("starts further apart than slowest repeat");
endmodule // light_sensor_regs_sva
bind light_sensor_regs light_sensor_regs_sva #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) sva_i (
  .clock, .rst_n, .meas_enable, .mode_wr, .conv_start, .resolution_code, .gain_code);
